// [logic/iplr_field_decode.sv]
// Purpose: one source's gate and level tag from its 2-bit priority field
// Assumes: source request is a level on the same clock
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module iplr_field_decode
  import iplr_pkg::*;
(
  // field and source
  input  wire logic [1:0] field,
  input  wire logic       src_req,
  // tagged request
  output iplr_req_t       req
);
  always_comb begin
    req.valid = src_req && (field != IPLR_FIELD_OFF);
    unique case (field)
      IPLR_FIELD_L2: req.level = IPLR_LVL2;
      IPLR_FIELD_L1: req.level = IPLR_LVL1;
      default:       req.level = IPLR_LVL0;
    endcase
  end
endmodule
`default_nettype wire

// [logic/iplr_pkg.sv]
// Purpose: shared constants and types for the priority level register block
// Assumes: AHB-Lite word access, 16-bit registers in the low half of the word
// Notes:   printed offsets are indices; byte address is four times the index
`default_nettype none
package iplr_pkg;
  localparam int unsigned IPLR_NUM_SRC = 23;
  localparam logic [3:0]  IPLR_IDX_TIMER = 4'h7;
  localparam logic [3:0]  IPLR_IDX_SERIAL = 4'h8;
  localparam logic [3:0]  IPLR_IDX_PWM = 4'h9;
  localparam logic [11:0] IPLR_ADDR_TIMER = {8'h00, IPLR_IDX_TIMER} << 2;
  localparam logic [11:0] IPLR_ADDR_SERIAL = {8'h00, IPLR_IDX_SERIAL} << 2;
  localparam logic [11:0] IPLR_ADDR_PWM = {8'h00, IPLR_IDX_PWM} << 2;
  localparam logic [15:0] IPLR_RESET_VAL = 16'h0000;
  // writable bits; bits 11:10 of the serial register are reserved
  localparam logic [15:0] IPLR_MASK_TIMER = 16'hFFFF;
  localparam logic [15:0] IPLR_MASK_SERIAL = 16'hF3FF;
  localparam logic [15:0] IPLR_MASK_PWM = 16'hFFFF;
  localparam logic [1:0]  IPLR_FIELD_OFF = 2'h0;
  localparam logic [1:0]  IPLR_FIELD_L0 = 2'h1;
  localparam logic [1:0]  IPLR_FIELD_L1 = 2'h2;
  localparam logic [1:0]  IPLR_FIELD_L2 = 2'h3;
  localparam logic [1:0]  IPLR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  IPLR_HSIZE_WORD = 3'h2;
  localparam logic [31:0] IPLR_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    IPLR_LVL0,
    IPLR_LVL1,
    IPLR_LVL2
  } iplr_level_t;

  typedef struct packed {
    logic        valid;
    iplr_level_t level;
  } iplr_req_t;

  typedef struct packed {
    logic [15:0] timer_group_priority_reg;
    logic [15:0] serial_timer_priority_reg;
    logic [15:0] pwm_converter_priority_reg;
  } iplr_regs_t;
endpackage
`default_nettype wire

// [logic/iplr_regs.sv]
// Purpose: three interrupt priority level registers with AHB-Lite access
// Assumes: single clock, word transfers, zero wait states
// Notes:   source index 0 is the lowest field of the pwm register, see field map
`timescale 1ns/1ps
`default_nettype none
module iplr_regs
  import iplr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)(
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [ADDR_W-1:0]       haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // interrupt sources, same clock domain
  input  wire logic [IPLR_NUM_SRC-1:0] src_pending,
  // tagged requests to arbitration
  output iplr_req_t [IPLR_NUM_SRC-1:0] arb_req,
  // register contents for the controller
  output iplr_regs_t                   levels
);

  logic [15:0]       timer_r;
  logic [15:0]       serial_r;
  logic [15:0]       pwm_r;
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [31:0]       rdata_r;
  logic              access;
  logic [47:0]       all_fields;
  logic [2:0]        wr_sel;
  logic [2:0]        addr_sel;
  // one named field per source, taken straight from the register bits
  logic [1:0]        timer_a_ch0_level;
  logic [1:0]        timer_b_ch3_level;
  logic [1:0]        timer_b_ch2_level;
  logic [1:0]        timer_b_ch1_level;
  logic [1:0]        timer_b_ch0_level;
  logic [1:0]        timer_c_ch3_level;
  logic [1:0]        timer_c_ch2_level;
  logic [1:0]        timer_c_ch1_level;
  logic [1:0]        serial0_rx_full_level;
  logic [1:0]        serial0_rx_error_level;
  logic [1:0]        serial0_tx_idle_level;
  logic [1:0]        serial0_tx_empty_level;
  logic [1:0]        timer_a_ch3_level;
  logic [1:0]        timer_a_ch2_level;
  logic [1:0]        timer_a_ch1_level;
  logic [1:0]        pwm_first_fault_level;
  logic [1:0]        pwm_second_fault_level;
  logic [1:0]        pwm_first_reload_level;
  logic [1:0]        pwm_second_reload_level;
  logic [1:0]        conv_first_zero_cross_level;
  logic [1:0]        conv_second_zero_cross_level;
  logic [1:0]        conv_first_done_level;
  logic [1:0]        conv_second_done_level;

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = {a[11:0] == IPLR_ADDR_TIMER, a[11:0] == IPLR_ADDR_SERIAL,
               a[11:0] == IPLR_ADDR_PWM};
  endfunction

  assign access    = hsel && hready && (htrans == IPLR_HTRANS_NONSEQ);
  assign wr_sel    = reg_sel(wr_addr_r);
  assign addr_sel  = reg_sel(haddr);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // write address captured in address phase, data used in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= access && hwrite && (hsize == IPLR_HSIZE_WORD);
      wr_addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r  <= IPLR_RESET_VAL;
      serial_r <= IPLR_RESET_VAL;
      pwm_r    <= IPLR_RESET_VAL;
    end else if (wr_pend_r) begin
      if (wr_sel[2]) timer_r <= hwdata[15:0] & IPLR_MASK_TIMER;
      if (wr_sel[1]) serial_r <= hwdata[15:0] & IPLR_MASK_SERIAL;
      if (wr_sel[0]) pwm_r <= hwdata[15:0] & IPLR_MASK_PWM;
    end
  end

  // read data registered so it stands through the data phase; unmapped reads zero.
  // a read right after a write to the same register returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= IPLR_RDATA_ZERO;
    end else if (access && !hwrite) begin
      unique case (1'b1)
        addr_sel[2]: rdata_r <= {16'h0000, timer_r};
        addr_sel[1]: rdata_r <= {16'h0000, serial_r & IPLR_MASK_SERIAL};
        addr_sel[0]: rdata_r <= {16'h0000, pwm_r};
        default:           rdata_r <= IPLR_RDATA_ZERO;
      endcase
    end
  end

  assign levels.timer_group_priority_reg   = timer_r;
  assign levels.serial_timer_priority_reg  = serial_r;
  assign levels.pwm_converter_priority_reg = pwm_r;

  // named view of each field; kept apart from all_fields so the checks below compare two maps
  assign timer_a_ch0_level            = timer_r[15:14];
  assign timer_b_ch3_level            = timer_r[13:12];
  assign timer_b_ch2_level            = timer_r[11:10];
  assign timer_b_ch1_level            = timer_r[9:8];
  assign timer_b_ch0_level            = timer_r[7:6];
  assign timer_c_ch3_level            = timer_r[5:4];
  assign timer_c_ch2_level            = timer_r[3:2];
  assign timer_c_ch1_level            = timer_r[1:0];
  assign serial0_rx_full_level        = serial_r[15:14];
  assign serial0_rx_error_level       = serial_r[13:12];
  assign serial0_tx_idle_level        = serial_r[9:8];
  assign serial0_tx_empty_level       = serial_r[7:6];
  assign timer_a_ch3_level            = serial_r[5:4];
  assign timer_a_ch2_level            = serial_r[3:2];
  assign timer_a_ch1_level            = serial_r[1:0];
  assign pwm_first_fault_level        = pwm_r[15:14];
  assign pwm_second_fault_level       = pwm_r[13:12];
  assign pwm_first_reload_level       = pwm_r[11:10];
  assign pwm_second_reload_level      = pwm_r[9:8];
  assign conv_first_zero_cross_level  = pwm_r[7:6];
  assign conv_second_zero_cross_level = pwm_r[5:4];
  assign conv_first_done_level        = pwm_r[3:2];
  assign conv_second_done_level       = pwm_r[1:0];

  // level a field stands for; a disabled field carries level 0 but no valid
  function automatic iplr_level_t field_level(input logic [1:0] f);
    unique case (f)
      IPLR_FIELD_OFF: field_level = IPLR_LVL0;
      IPLR_FIELD_L0:  field_level = IPLR_LVL0;
      IPLR_FIELD_L1:  field_level = IPLR_LVL1;
      IPLR_FIELD_L2:  field_level = IPLR_LVL2;
    endcase
  endfunction

  // source i uses bits 2i+3:2i+2 of this vector; the reserved pair is skipped.
  // timer: a0 15:14, b3 13:12, b2 11:10, b1 9:8, b0 7:6, c3 5:4, c2 3:2, c1 1:0
  // serial: rx full 15:14, rx err 13:12, tx idle 9:8, tx empty 7:6, a3/a2/a1
  // pwm: faults 15:12, reloads 11:8, zero cross 7:4, conversions done 3:0
  assign all_fields = {timer_r,
                       serial_r[15:12],
                       serial_r[9:6],
                       serial_r[5:0],
                       pwm_r[15:12],
                       pwm_r[11:8],
                       pwm_r[7:6],
                       pwm_r[5:0],
                       2'h0};

  genvar g;
  generate
    for (g = 0; g < IPLR_NUM_SRC; g++) begin : g_src
      iplr_field_decode u_dec (
        .field   (all_fields[2*g+3 -: 2]),
        .src_req (src_pending[g]),
        .req     (arb_req[g])
      );
    end
  endgenerate

  property p_gate(int i);
    @(posedge hclk) disable iff (!hresetn)
      arb_req[i].valid == (src_pending[i] && all_fields[2*i+3 -: 2] != IPLR_FIELD_OFF);
  endproperty
  a_gate_src0: assert property (p_gate(0)) else $error("source 0 gate wrong");
  a_gate_src22: assert property (p_gate(22)) else $error("source 22 gate wrong");

  a_level_max: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[0].valid && pwm_r[1:0] == IPLR_FIELD_L2 |-> arb_req[0].level == IPLR_LVL2)
    else $error("level 2 decode wrong");
  a_level_low: assert property (@(posedge hclk) disable iff (!hresetn)
    pwm_r[1:0] == IPLR_FIELD_L0 |-> arb_req[0].level == IPLR_LVL0)
    else $error("level 0 decode wrong");

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_r[11:10] == 2'h0) else $error("reserved bits set");

  a_read_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    access && !hwrite && addr_sel[1] |=> hrdata[11:10] == 2'h0)
    else $error("reserved bits read nonzero");

  sequence s_wr_serial;
    access && hwrite && addr_sel[1] ##1 1'b1;
  endsequence
  a_write_serial: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_serial |=> serial_r == ($past(hwdata[15:0]) & IPLR_MASK_SERIAL))
    else $error("serial register write lost");

  a_write_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_sel[2] |=> timer_r[15:14] == $past(hwdata[15:14]))
    else $error("timer a ch0 field not written");

  a_write_pwm: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_sel[0] |=> pwm_r == $past(hwdata[15:0]))
    else $error("pwm register write lost");

  a_read_pwm: assert property (@(posedge hclk) disable iff (!hresetn)
    access && !hwrite && addr_sel[0] && !wr_pend_r |=> hrdata == {16'h0000, pwm_r})
    else $error("pwm register read wrong");

  a_hold_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_r |=> $stable(timer_r)) else $error("timer register changed");

  a_hold_serial: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_r |=> $stable(serial_r))
    else $error("serial register changed");

  a_reset_clear: assert property (@(posedge hclk)
    $rose(hresetn) |-> timer_r == IPLR_RESET_VAL && serial_r == IPLR_RESET_VAL &&
                       pwm_r == IPLR_RESET_VAL)
    else $error("fields not cleared by reset");

  // timer register sources: gate and level per named field
  a_map_timer_a0: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[22] == {src_pending[22] && timer_a_ch0_level != IPLR_FIELD_OFF,
                    field_level(timer_a_ch0_level)})
    else $error("timer a ch0 request wrong");
  a_map_timer_b3: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[21] == {src_pending[21] && timer_b_ch3_level != IPLR_FIELD_OFF,
                    field_level(timer_b_ch3_level)})
    else $error("timer b ch3 request wrong");
  a_map_timer_b2: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[20] == {src_pending[20] && timer_b_ch2_level != IPLR_FIELD_OFF,
                    field_level(timer_b_ch2_level)})
    else $error("timer b ch2 request wrong");
  a_map_timer_b1: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[19] == {src_pending[19] && timer_b_ch1_level != IPLR_FIELD_OFF,
                    field_level(timer_b_ch1_level)})
    else $error("timer b ch1 request wrong");
  a_map_timer_b0: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[18] == {src_pending[18] && timer_b_ch0_level != IPLR_FIELD_OFF,
                    field_level(timer_b_ch0_level)})
    else $error("timer b ch0 request wrong");
  a_map_timer_c3: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[17] == {src_pending[17] && timer_c_ch3_level != IPLR_FIELD_OFF,
                    field_level(timer_c_ch3_level)})
    else $error("timer c ch3 request wrong");
  a_map_timer_c2: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[16] == {src_pending[16] && timer_c_ch2_level != IPLR_FIELD_OFF,
                    field_level(timer_c_ch2_level)})
    else $error("timer c ch2 request wrong");
  a_map_timer_c1: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[15] == {src_pending[15] && timer_c_ch1_level != IPLR_FIELD_OFF,
                    field_level(timer_c_ch1_level)})
    else $error("timer c ch1 request wrong");

  // serial register sources; the reserved pair has no source
  a_map_rx_full: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[14] == {src_pending[14] && serial0_rx_full_level != IPLR_FIELD_OFF,
                    field_level(serial0_rx_full_level)})
    else $error("rx full request wrong");
  a_map_rx_error: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[13] == {src_pending[13] && serial0_rx_error_level != IPLR_FIELD_OFF,
                    field_level(serial0_rx_error_level)})
    else $error("rx error request wrong");
  a_map_tx_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[12] == {src_pending[12] && serial0_tx_idle_level != IPLR_FIELD_OFF,
                    field_level(serial0_tx_idle_level)})
    else $error("tx idle request wrong");
  a_map_tx_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[11] == {src_pending[11] && serial0_tx_empty_level != IPLR_FIELD_OFF,
                    field_level(serial0_tx_empty_level)})
    else $error("tx empty request wrong");
  a_map_timer_a3: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[10] == {src_pending[10] && timer_a_ch3_level != IPLR_FIELD_OFF,
                    field_level(timer_a_ch3_level)})
    else $error("timer a ch3 request wrong");
  a_map_timer_a2: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[9] == {src_pending[9] && timer_a_ch2_level != IPLR_FIELD_OFF,
                   field_level(timer_a_ch2_level)})
    else $error("timer a ch2 request wrong");
  a_map_timer_a1: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[8] == {src_pending[8] && timer_a_ch1_level != IPLR_FIELD_OFF,
                   field_level(timer_a_ch1_level)})
    else $error("timer a ch1 request wrong");

  // pwm and converter register sources
  a_map_fault_one: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[7] == {src_pending[7] && pwm_first_fault_level != IPLR_FIELD_OFF,
                   field_level(pwm_first_fault_level)})
    else $error("first pwm fault request wrong");
  a_map_fault_two: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[6] == {src_pending[6] && pwm_second_fault_level != IPLR_FIELD_OFF,
                   field_level(pwm_second_fault_level)})
    else $error("second pwm fault request wrong");
  a_map_reload_one: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[5] == {src_pending[5] && pwm_first_reload_level != IPLR_FIELD_OFF,
                   field_level(pwm_first_reload_level)})
    else $error("first pwm reload request wrong");
  a_map_reload_two: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[4] == {src_pending[4] && pwm_second_reload_level != IPLR_FIELD_OFF,
                   field_level(pwm_second_reload_level)})
    else $error("second pwm reload request wrong");
  a_map_zc_one: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[3] == {src_pending[3] && conv_first_zero_cross_level != IPLR_FIELD_OFF,
                   field_level(conv_first_zero_cross_level)})
    else $error("first zero cross request wrong");
  a_map_zc_two: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[2] == {src_pending[2] && conv_second_zero_cross_level != IPLR_FIELD_OFF,
                   field_level(conv_second_zero_cross_level)})
    else $error("second zero cross request wrong");
  a_map_done_one: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[1] == {src_pending[1] && conv_first_done_level != IPLR_FIELD_OFF,
                   field_level(conv_first_done_level)})
    else $error("first conversion done request wrong");
  a_map_done_two: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_req[0] == {src_pending[0] && conv_second_done_level != IPLR_FIELD_OFF,
                   field_level(conv_second_done_level)})
    else $error("second conversion done request wrong");

endmodule
`default_nettype wire

// [verif/iplr_src_model.sv]
// Purpose: interrupt source model driving the pending levels
// Assumes: sources run on the bus clock
// Notes:   a flag shows one edge after it is asked for, as a real source flop would
`timescale 1ns/1ps
`default_nettype none
module iplr_src_model
  import iplr_pkg::*;
(
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // requested pattern and pending flags
  input  wire logic [IPLR_NUM_SRC-1:0] pend_cmd,
  output logic [IPLR_NUM_SRC-1:0]      src_pending
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) src_pending <= '0;
    else src_pending <= pend_cmd;
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench for the priority level registers
// Assumes: zero wait state slave, hready fed back from hreadyout
// Notes:   arb_req is combinational, so it is sampled 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iplr_pkg::*;
  logic                         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0]                  haddr;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic [31:0]                  hwdata, hrdata, q;
  logic [IPLR_NUM_SRC-1:0]      pend_cmd, src_pending;
  iplr_req_t [IPLR_NUM_SRC-1:0] arb_req;
  iplr_regs_t                   levels;
  int                           error_cnt = 0;
  int                           compares = 0;
  iplr_src_model i_iplr_src_model (.hclk(hclk), .hresetn(hresetn), .pend_cmd(pend_cmd),
    .src_pending(src_pending));
  iplr_regs i_iplr_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_pending(src_pending),
    .arb_req(arb_req), .levels(levels));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // the master waits on hready rather than assuming zero wait states
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= IPLR_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  function automatic logic [IPLR_NUM_SRC-1:0] vb();
    for (int i = 0; i < IPLR_NUM_SRC; i++) vb[i] = arb_req[i].valid;
  endfunction
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_reset;
    for (int k = 0; k < 3; k++) begin
      xfer(1'b0, IPLR_ADDR_TIMER + 12'(4 * k), 32'h0);
      chk(q, 64'h0);
    end
    #1 chk(vb(), 64'h0);
    chk(levels, 64'h0);
    chk({hreadyout, hresp}, 64'h2);
    @(posedge hclk);
    $display("test reset done");
  endtask
  task t_rw;
    for (int k = 0; k < 4; k++) xfer(1'b1, IPLR_ADDR_TIMER + 12'(4 * k), 32'hFFFF_FFFF);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, IPLR_ADDR_TIMER + 12'(4 * k), 32'h0);
      chk(q, (k == 1) ? 64'hF3FF : (k == 3) ? 64'h0 : 64'hFFFF);
    end
    chk(levels, 64'hFFFF_F3FF_FFFF);
    $display("test read write done");
  endtask
  task t_decode;
    logic [15:0] f;
    for (int v = 0; v < 4; v++) begin
      f = {8{v[1:0]}};
      for (int k = 0; k < 3; k++) xfer(1'b1, IPLR_ADDR_TIMER + 12'(4 * k), {16'h0, f});
      pend_cmd <= 23'h2A_AAAA;
      repeat (2) @(posedge hclk);
      #1 chk(vb(), (v != 0) ? 64'h2A_AAAA : 64'h0);
      for (int i = 0; i < IPLR_NUM_SRC; i++) if (v != 0) chk(arb_req[i].level, v - 1);
      @(posedge hclk);
    end
    $display("test decode done");
  endtask
  task t_map;
    logic [11:0] a;
    int          p;
    pend_cmd <= '1;
    for (int k = 0; k < 3; k++) xfer(1'b1, IPLR_ADDR_TIMER + 12'(4 * k), 32'h0);
    for (int i = 0; i < IPLR_NUM_SRC; i++) begin
      a = (i > 14) ? IPLR_ADDR_TIMER : (i > 7) ? IPLR_ADDR_SERIAL : IPLR_ADDR_PWM;
      p = (i > 14) ? 2 * (i - 15) : (i > 12) ? 2 * (i - 7) : (i > 7) ? 2 * (i - 8) : 2 * i;
      xfer(1'b1, a, 32'h3 << p);
      // one idle edge sits between the write and the read; xfer ends the write's data phase first, so the read returns the new value without it
      @(posedge hclk);
      xfer(1'b0, a, 32'h0);
      chk(q, 64'h3 << p);
      #1 chk(vb(), 64'h1 << i);
      @(posedge hclk);
      xfer(1'b1, a, 32'h0);
    end
    $display("test field map done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = IPLR_HSIZE_WORD;
    hwdata = 32'h0;
    pend_cmd = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_rw;
    t_decode;
    t_map;
    report_and_stop;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule
`default_nettype wire
